// File: verilog/dcs_regs.sv
// Diskette control and status registers on the I/O port bus
`timescale 1ns/1ps

// What this block does
// - Read-only status byte at port 03F0
// - Status A: irq, drq, step, track0, head, index, wp, dir
// - Read-only drive signal byte at port 03F1
// - Status B: install, selects, latched write/read/enable
// - Write-only control at 03F2, cleared on reset
// - Motor enables and DMA/interrupt gate bit
// - Active-low controller reset, drive select field
// - Port 03F7 read: change, gate, precomp, rate
// - Rate codes 00=500K, 10=250K, 01=300K
// - Port 03F7 write loads rate and precomp
// - Fixed 125 ns precompensation on all cylinders
// - High density 500K, low density 300K
module dcs_regs
	import dcs_pkg::*;
(
	// Clock, reset, enable
	input  wire logic        MCLK,
	input  wire logic        RESET_N,
	input  wire logic        CE,
	// I/O port bus
	input  wire logic [15:0] IO_ADDR,
	input  wire logic [7:0]  IO_WDATA,
	input  wire logic        IO_RD,
	input  wire logic        IO_WR,
	output logic      [7:0]  IO_RDATA,
	// Controller core and drive cable
	input  wire dcs_core_t   CORE,
	input  wire dcs_pins_t   PINS,
	// Drive and core controls
	output logic      [1:0]  MOTOR_EN,
	output logic      [1:0]  DRIVE_SEL_N,
	output logic             CORE_RESET_N,
	output logic             IRQ_OUT,
	output logic             DRQ_OUT,
	output logic      [1:0]  DATA_RATE,
	output logic      [4:0]  PRECOMP_CYC,
	output logic      [9:0]  CELL_CYC
);

	logic      [7:0] motor_sel_ff;
	logic      [7:0] rate_ctl_ff;
	dcs_pins_t       pins_s1_ff;
	dcs_pins_t       pins_s2_ff;
	logic            step_lat_ff;
	logic            wdat_lat_ff;
	logic            rdat_lat_ff;
	logic            wen_lat_ff;
	logic      [7:0] stat_a;
	logic      [7:0] stat_b;
	logic      [7:0] dig_in;
	logic      [7:0] nxt_rdata;
	logic            gate_en;
	logic            sel1;
	logic            core_run;
	dcs_rate_t       rate;

	assign gate_en = motor_sel_ff[DCS_MS_GATE_BIT];
	assign sel1    = motor_sel_ff[DCS_MS_SEL_BIT];
	assign core_run = motor_sel_ff[DCS_MS_RESET_BIT];
	assign rate    = dcs_rate_t'(rate_ctl_ff[DCS_RC_RATE_LSB +: 2]);

	// Drive cable lines cross into MCLK
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			pins_s1_ff <= '0;
			pins_s2_ff <= '0;
		end else if (CE) begin
			pins_s1_ff <= PINS;
			pins_s2_ff <= pins_s1_ff;
		end
	end

	// Motor and select control byte
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			motor_sel_ff <= DCS_MS_RESET_VAL;
		end else if (CE && IO_WR && IO_ADDR == DCS_ADDR_MOTOR_SEL) begin
			motor_sel_ff <= {2'h0, IO_WDATA[5:0]};
		end
	end

	// Rate and precompensation byte; upper bits kept zero
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rate_ctl_ff <= DCS_RC_RESET_VAL;
		end else if (CE && IO_WR && IO_ADDR == DCS_ADDR_RATE) begin
			rate_ctl_ff <= {5'h00, IO_WDATA[2:0]};
		end
	end

	// Latched pulse capture; while the core is in reset each bit only follows its pulse, it is not held
	dcs_sticky_bit #(
		.WIDTH(1)
	) u_step_lat (
		.clk       (MCLK),
		.rst_n     (RESET_N),
		.ce        (CE),
		.set_in    (CORE.step),
		.hold      (core_run),
		.sticky_ff (step_lat_ff)
	);

	dcs_sticky_bit #(
		.WIDTH(1)
	) u_wdat_lat (
		.clk       (MCLK),
		.rst_n     (RESET_N),
		.ce        (CE),
		.set_in    (CORE.wr_data),
		.hold      (core_run),
		.sticky_ff (wdat_lat_ff)
	);

	dcs_sticky_bit #(
		.WIDTH(1)
	) u_rdat_lat (
		.clk       (MCLK),
		.rst_n     (RESET_N),
		.ce        (CE),
		.set_in    (CORE.rd_data),
		.hold      (core_run),
		.sticky_ff (rdat_lat_ff)
	);

	dcs_sticky_bit #(
		.WIDTH(1)
	) u_wen_lat (
		.clk       (MCLK),
		.rst_n     (RESET_N),
		.ce        (CE),
		.set_in    (CORE.wr_en),
		.hold      (core_run),
		.sticky_ff (wen_lat_ff)
	);

	// Status byte assembly
	always_comb begin
		stat_a = 8'h00;
		stat_a[DCS_SA_IRQ_BIT]   = CORE.irq;
		stat_a[DCS_SA_DRQ_BIT]   = CORE.drq;
		stat_a[DCS_SA_STEP_BIT]  = step_lat_ff;
		stat_a[DCS_SA_TRK0_BIT]  = pins_s2_ff.track0;
		stat_a[DCS_SA_HEAD_BIT]  = CORE.head1_sel_n;
		stat_a[DCS_SA_INDEX_BIT] = pins_s2_ff.index;
		stat_a[DCS_SA_WPROT_BIT] = pins_s2_ff.wr_protect;
		stat_a[DCS_SA_DIR_BIT]   = CORE.dir_n;
	end

	always_comb begin
		stat_b = 8'h00;
		stat_b[DCS_SB_INST_BIT] = pins_s2_ff.drive2_inst_n;
		stat_b[DCS_SB_SEL1_BIT] = DRIVE_SEL_N[1];
		stat_b[DCS_SB_SEL0_BIT] = DRIVE_SEL_N[0];
		stat_b[DCS_SB_WDAT_BIT] = wdat_lat_ff;
		stat_b[DCS_SB_RDAT_BIT] = rdat_lat_ff;
		stat_b[DCS_SB_WEN_BIT]  = wen_lat_ff;
	end

	always_comb begin
		dig_in = 8'h00;
		dig_in[DCS_DI_CHG_BIT]         = pins_s2_ff.change_n;
		dig_in[DCS_DI_GATE_BIT]        = gate_en;
		dig_in[DCS_DI_NOPRE_BIT]       = rate_ctl_ff[DCS_RC_NOPRE_BIT];
		dig_in[DCS_RC_RATE_LSB +: 2]   = rate_ctl_ff[DCS_RC_RATE_LSB +: 2];
	end

	// Read decode; write-only ports and unmapped addresses read zero
	always_comb begin
		unique case (IO_ADDR)
			DCS_ADDR_STAT_A: nxt_rdata = stat_a;
			DCS_ADDR_STAT_B: nxt_rdata = stat_b;
			DCS_ADDR_RATE:   nxt_rdata = dig_in;
			default:         nxt_rdata = 8'h00;
		endcase
	end

	// Read data registered, holds until the next read; reads have no side effects
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			IO_RDATA <= 8'h00;
		end else if (CE && IO_RD) begin
			IO_RDATA <= nxt_rdata;
		end
	end

	// Drive controls
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			MOTOR_EN <= 2'h0;
		end else if (CE) begin
			MOTOR_EN <= {motor_sel_ff[DCS_MS_MOTOR1_BIT], motor_sel_ff[DCS_MS_MOTOR0_BIT]};
		end
	end

	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			DRIVE_SEL_N <= 2'h3;
		end else if (CE) begin
			DRIVE_SEL_N <= {~sel1, sel1};
		end
	end

	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			CORE_RESET_N <= 1'b0;
		end else if (CE) begin
			CORE_RESET_N <= motor_sel_ff[DCS_MS_RESET_BIT];
		end
	end

	// Gate low keeps the core's requests off the system lines
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			IRQ_OUT <= 1'b0;
		end else if (CE) begin
			IRQ_OUT <= CORE.irq & gate_en;
		end
	end

	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			DRQ_OUT <= 1'b0;
		end else if (CE) begin
			DRQ_OUT <= CORE.drq & gate_en;
		end
	end

	// Bit cell and precompensation timing for the core
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			DATA_RATE <= 2'h0;
		end else if (CE) begin
			DATA_RATE <= rate;
		end
	end

	// Same shift on every cylinder, no track dependence
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			PRECOMP_CYC <= 5'h00;
		end else if (CE) begin
			PRECOMP_CYC <= rate_ctl_ff[DCS_RC_NOPRE_BIT] ? 5'h00 : 5'(DCS_PRECOMP_CYC);
		end
	end

	// Reserved rate code falls back to the fastest rate
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			CELL_CYC <= 10'(DCS_CELL_500_CYC);
		end else if (CE) begin
			unique case (rate)
				DCS_RATE_500K: CELL_CYC <= 10'(DCS_CELL_500_CYC);
				DCS_RATE_300K: CELL_CYC <= 10'(DCS_CELL_300_CYC);
				DCS_RATE_250K: CELL_CYC <= 10'(DCS_CELL_250_CYC);
				DCS_RATE_RSVD: CELL_CYC <= 10'(DCS_CELL_500_CYC);
			endcase
		end
	end

endmodule : dcs_regs

// Sticky capture bit: set by a pulse, kept only while hold is high
module dcs_sticky_bit
	import dcs_pkg::*;
#(
	parameter int WIDTH = 1
) (
	// Clock, reset, enable
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             ce,
	// Pulse in, hold enable, sticky level out
	input  wire logic [WIDTH-1:0] set_in,
	input  wire logic             hold,
	output logic      [WIDTH-1:0] sticky_ff
);

	// Set wins over clear so a pulse during reset release is kept
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sticky_ff <= '0;
		end else if (ce) begin
			sticky_ff <= set_in | (sticky_ff & {WIDTH{hold}});
		end
	end

endmodule : dcs_sticky_bit

// File: verilog/dcs_pkg.sv
// Package for the diskette control and status register set
package dcs_pkg;

	// I/O port addresses
	localparam logic [15:0] DCS_ADDR_STAT_A    = 16'h03f0;
	localparam logic [15:0] DCS_ADDR_STAT_B    = 16'h03f1;
	localparam logic [15:0] DCS_ADDR_MOTOR_SEL = 16'h03f2;
	localparam logic [15:0] DCS_ADDR_RATE      = 16'h03f7;

	// Motor and select control fields
	localparam int DCS_MS_MOTOR1_BIT = 5;
	localparam int DCS_MS_MOTOR0_BIT = 4;
	localparam int DCS_MS_GATE_BIT   = 3;
	localparam int DCS_MS_RESET_BIT  = 2;
	localparam int DCS_MS_SEL_BIT    = 0;
	localparam logic [7:0] DCS_MS_RESET_VAL = 8'h00;

	// Rate and precompensation control fields
	localparam int DCS_RC_NOPRE_BIT = 2;
	localparam int DCS_RC_RATE_LSB  = 0;
	localparam logic [7:0] DCS_RC_RESET_VAL = 8'h00;

	// Status byte and port 03F7 read byte bit positions
	localparam int DCS_SA_IRQ_BIT   = 7;
	localparam int DCS_SA_DRQ_BIT   = 6;
	localparam int DCS_SA_STEP_BIT  = 5;
	localparam int DCS_SA_TRK0_BIT  = 4;
	localparam int DCS_SA_HEAD_BIT  = 3;
	localparam int DCS_SA_INDEX_BIT = 2;
	localparam int DCS_SA_WPROT_BIT = 1;
	localparam int DCS_SA_DIR_BIT   = 0;
	localparam int DCS_SB_INST_BIT  = 7;
	localparam int DCS_SB_SEL1_BIT  = 6;
	localparam int DCS_SB_SEL0_BIT  = 5;
	localparam int DCS_SB_WDAT_BIT  = 4;
	localparam int DCS_SB_RDAT_BIT  = 3;
	localparam int DCS_SB_WEN_BIT   = 2;
	localparam int DCS_DI_CHG_BIT   = 7;
	localparam int DCS_DI_GATE_BIT  = 3;
	localparam int DCS_DI_NOPRE_BIT = 2;

	// Data rate encodings
	typedef enum logic [1:0] {
		DCS_RATE_500K = 2'b00,
		DCS_RATE_300K = 2'b01,
		DCS_RATE_250K = 2'b10,
		DCS_RATE_RSVD = 2'b11
	} dcs_rate_t;

	// Timing
	localparam int DCS_CLK_PERIOD_PS = 5000;
	localparam int DCS_PRECOMP_NS    = 125;
	localparam int DCS_PRECOMP_CYC   = (DCS_PRECOMP_NS * 1000) / DCS_CLK_PERIOD_PS;
	localparam int DCS_KBPS_500      = 500;
	localparam int DCS_KBPS_300      = 300;
	localparam int DCS_KBPS_250      = 250;
	localparam int DCS_CELL_500_CYC  = 1000000000 / (DCS_KBPS_500 * DCS_CLK_PERIOD_PS);
	localparam int DCS_CELL_300_CYC  = 1000000000 / (DCS_KBPS_300 * DCS_CLK_PERIOD_PS);
	localparam int DCS_CELL_250_CYC  = 1000000000 / (DCS_KBPS_250 * DCS_CLK_PERIOD_PS);

	// Signals from the controller core, same clock
	typedef struct packed {
		logic irq;
		logic drq;
		logic step;
		logic head1_sel_n;
		logic dir_n;
		logic wr_data;
		logic rd_data;
		logic wr_en;
	} dcs_core_t;

	// Signals from the drive cable, asynchronous
	typedef struct packed {
		logic index;
		logic track0;
		logic wr_protect;
		logic change_n;
		logic drive2_inst_n;
	} dcs_pins_t;

endpackage : dcs_pkg

// File: bench/dcs_properties.sv
// Assertions on the diskette register ports
`timescale 1ns/1ps
module dcs_properties
	import dcs_pkg::*;
(
	input wire logic        MCLK, RESET_N, CE, IO_RD, IO_WR, CORE_RESET_N, IRQ_OUT, DRQ_OUT,
	input wire logic [15:0] IO_ADDR,
	input wire logic [7:0]  IO_WDATA, IO_RDATA,
	input wire logic [1:0]  MOTOR_EN, DRIVE_SEL_N, DATA_RATE,
	input wire logic [4:0]  PRECOMP_CYC,
	input wire logic [9:0]  CELL_CYC,
	input wire dcs_core_t   CORE,
	input wire dcs_pins_t   PINS
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RESET_N);
	sequence wr_at(a); CE && IO_WR && IO_ADDR == a; endsequence
	sequence rd_at(a); CE && IO_RD && !IO_WR && IO_ADDR == a; endsequence
	sequence gate_off_wr; CE && IO_WR && IO_ADDR == 16'h03f2 && !IO_WDATA[3]; endsequence
	wo_read_a: assert property (rd_at(16'h03f2) |=> IO_RDATA == 8'h00) else $error("wo read");
	rdata_hold_a: assert property (!(CE && IO_RD) |=> $stable(IO_RDATA)) else $error("rdata moved");
	// Output follows the core request one enabled edge later
	irq_gate_a: assert property ($past(CE) && IRQ_OUT |-> $past(CORE.irq)) else $error("irq");
	gate_off_a: assert property (gate_off_wr ##1 CE |=> !IRQ_OUT && !DRQ_OUT) else $error("gate off");
	motor_out_a: assert property (wr_at(16'h03f2) |-> ##2 MOTOR_EN == $past(IO_WDATA[5:4], 2)) else $error("motor");
	select_out_a: assert property (wr_at(16'h03f2) |-> ##2 CORE_RESET_N == $past(IO_WDATA[2], 2)
		&& DRIVE_SEL_N == ($past(IO_WDATA[0], 2) ? 2'h1 : 2'h2)) else $error("select");
	rate_out_a: assert property (wr_at(16'h03f7) |-> ##2 DATA_RATE == $past(IO_WDATA[1:0], 2)
		&& PRECOMP_CYC == ($past(IO_WDATA[2], 2) ? 5'h00 : 5'h19)) else $error("rate");
	cell_len_a: assert property (CELL_CYC == (DATA_RATE == 2'h1 ? 10'h29a : DATA_RATE == 2'h2 ? 10'h320 : 10'h190))
		else $error("cell");
	rate_read_a: assert property (rd_at(16'h03f7) |=> IO_RDATA[6:4] == 3'h0 && IO_RDATA[1:0] == DATA_RATE)
		else $error("rate read");
endmodule : dcs_properties

// File: bench/dcs_drive_model.sv
// Behavioural pair of diskette drives on the cable
`timescale 1ns/1ps
module dcs_drive_model
	import dcs_pkg::*;
(
	input wire logic       MCLK,
	input wire logic [1:0] MOTOR_EN, DRIVE_SEL_N,
	input wire logic [3:0] LEVELS,
	output dcs_pins_t      PINS
);
	logic [5:0] turn_ff = 6'h00;
	logic       spin;
	// Only a selected drive with its motor on passes the index hole
	assign spin = |(MOTOR_EN & ~DRIVE_SEL_N);
	always @(posedge MCLK) turn_ff <= spin ? turn_ff + 6'h01 : 6'h00;
	assign PINS = {spin && turn_ff < 6'h08, LEVELS};
endmodule : dcs_drive_model

// File: bench/tb.sv
// Self-checking bench for the diskette register block
`timescale 1ns/1ps
module tb;
	import dcs_pkg::*;
	logic        MCLK = 0, RESET_N = 0, CE = 1, IO_RD = 0, IO_WR = 0, CORE_RESET_N, IRQ_OUT, DRQ_OUT;
	logic [15:0] IO_ADDR = 16'h0000;
	logic [7:0]  IO_WDATA = 8'h00, IO_RDATA, d;
	logic [1:0]  MOTOR_EN, DRIVE_SEL_N, DATA_RATE;
	logic [4:0]  PRECOMP_CYC;
	logic [9:0]  CELL_CYC;
	logic [3:0]  lv = 4'ha;
	dcs_core_t   CORE = 8'h00;
	dcs_pins_t   PINS;
	int          mismatches = 0, comparisons = 0, n;
	dcs_regs dut (
		.MCLK, .RESET_N, .CE, .IO_ADDR, .IO_WDATA, .IO_RD, .IO_WR, .IO_RDATA, .CORE, .PINS,
		.MOTOR_EN, .DRIVE_SEL_N, .CORE_RESET_N, .IRQ_OUT, .DRQ_OUT, .DATA_RATE, .PRECOMP_CYC, .CELL_CYC
	);
	dcs_drive_model u_drv (.MCLK, .MOTOR_EN, .DRIVE_SEL_N, .LEVELS(lv), .PINS);
	initial forever #2.5 MCLK = ~MCLK;
	task tick; @(posedge MCLK) #1; endtask : tick
	task chk(string nm, logic [9:0] seen, logic [9:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task wr(logic [15:0] a, logic [7:0] v);
		tick;
		{IO_WR, IO_ADDR, IO_WDATA} = {1'b1, a, v};
		tick;
		IO_WR = 0;
	endtask : wr
	task rd(logic [15:0] a);
		tick;
		{IO_RD, IO_ADDR} = {1'b1, a};
		tick;
		IO_RD = 0;
		d = IO_RDATA;
	endtask : rd
	task give_verdict;
		if (mismatches == 0 && comparisons > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : give_verdict
	task t_reset;
		tick;
		chk("sel", DRIVE_SEL_N, 2'h2);
		chk("motor", {CORE_RESET_N, MOTOR_EN}, 3'h0);
		rd(16'h03f7);
		chk("din", d, 8'h80);
	endtask : t_reset
	task t_motor;
		wr(16'h03f2, 8'hfd);
		tick;
		chk("ctl", {MOTOR_EN, DRIVE_SEL_N, CORE_RESET_N}, 5'h1b);
		rd(16'h03f2);
		chk("wo", d, 8'h00);
		rd(16'h03f7);
		chk("din", d, 8'h88);
		CORE = 8'hc0;
		tick;
		tick;
		chk("req", {IRQ_OUT, DRQ_OUT}, 2'h3);
		wr(16'h03f2, 8'h04);
		tick;
		chk("req", {IRQ_OUT, DRQ_OUT}, 2'h0);
		rd(16'h03f0);
		chk("sta", d[7:6], 2'h3);
		CORE = 8'h00;
	endtask : t_motor
	task t_rate;
		// Upper bits written as zero; code 11 checks the fallback cell
		for (int i = 0; i < 4; i++) begin
			wr(16'h03f7, {5'h00, i[0], i[1:0]});
			tick;
			chk("rate", DATA_RATE, i[1:0]);
			chk("cell", CELL_CYC, i == 1 ? 10'h29a : i == 2 ? 10'h320 : 10'h190);
			chk("pre", PRECOMP_CYC, i[0] ? 5'h00 : 5'h19);
			rd(16'h03f7);
			chk("din", d[2:0], {i[0], i[1:0]});
		end
	endtask : t_rate
	task t_status;
		CORE = 8'h3f;
		tick;
		CORE = 8'h18;
		rd(16'h03f0);
		chk("sta", d, 8'h39);
		rd(16'h03f1);
		chk("stb", d, 8'h5c);
		wr(16'h03f2, 8'h10);
		tick;
		rd(16'h03f1);
		chk("stb", d, 8'h40);
		lv = 4'h5;
		n = 0;
		// Two full turns sampled every other cycle
		repeat (64) begin
			rd(16'h03f0);
			n += d[2];
		end
		chk("index", n[9:0], 10'h008);
		chk("pins", {d[4], d[1]}, 2'h1);
		rd(16'h03f7);
		chk("chg", d[7], 1'h0);
	endtask : t_status
	task t_midreset;
		wr(16'h03f2, 8'h3d);
		wr(16'h03f7, 8'h06);
		RESET_N = 0;
		tick;
		chk("rst", {MOTOR_EN, DRIVE_SEL_N, CORE_RESET_N, DATA_RATE}, 7'h18);
		RESET_N = 1;
		tick;
		rd(16'h03f7);
		chk("rst din", d, 8'h00);
		chk("rst ctl", {MOTOR_EN, CORE_RESET_N}, 3'h0);
	endtask : t_midreset
	initial begin
		repeat (2) @(posedge MCLK);
		#1;
		RESET_N = 1;
		t_reset;
		t_motor;
		t_rate;
		t_status;
		t_midreset;
		give_verdict;
	end
	// Whole run needs under two hundred cycles
	initial begin
		#20000;
		mismatches++;
		give_verdict;
	end
endmodule : tb
bind dcs_regs dcs_properties u_chk (
	.MCLK, .RESET_N, .CE, .IO_RD, .IO_WR, .CORE_RESET_N, .IRQ_OUT, .DRQ_OUT, .IO_ADDR,
	.IO_WDATA, .IO_RDATA, .MOTOR_EN, .DRIVE_SEL_N, .DATA_RATE, .PRECOMP_CYC, .CELL_CYC, .CORE, .PINS
);
